// ==== bench/rtc_host_model.sv ====
// Host-side model: pull-ups on the open-drain lines and a watchdog kicker.
// Assumes the device only sinks its open-drain pins through their enables.
`timescale 1ns/1ps
`default_nettype none
module rtc_host_model (
  // Clock
  input wire logic sys_clk_i,
  // Bench control
  input wire logic kick_en_i,
  // Open-drain enables from the device
  input wire logic int_oe_i,
  input wire logic proc_rst_oe_i,
  // Resolved lines and kick pin
  output logic int_n_o,
  output logic rst_n_o,
  output var logic kick_o
);
  logic [3:0] kick_cnt; // Kick spacing, well inside every timeout
  // Pull-ups win whenever nobody sinks the line
  assign int_n_o = int_oe_i ? 1'b0 : 1'b1;
  assign rst_n_o = proc_rst_oe_i ? 1'b0 : 1'b1;
  initial begin
    kick_cnt = 4'h0;
    kick_o = 1'b0;
  end
  // Toggle the kick pin every 16 cycles while enabled
  always @(posedge sys_clk_i) begin
    kick_cnt <= kick_cnt + 4'h1;
    if (kick_en_i && kick_cnt == 4'hF) begin
      kick_o <= ~kick_o;
    end
  end
endmodule
`default_nettype wire

// ==== bench/rtc_irq_top_tb_top.sv ====
// Bench for the RTC interrupt block: alarm masks, backup, periodic rate,
// power fail, watchdog and the power-up battery check.
// Assumes short timer parameters; the host model pulls lines up.
`timescale 1ns/1ps
`default_nettype none
module rtc_irq_top_tb_top;
  // Pins driven by the bench
  logic sys_clk, resetn, cs_n, oe_n, we_n, upd, sfail, bkup, blow, kick_en;
  logic [3:0] addr;
  logic [7:0] dq, tsec, tmin, thour, tdate;
  // Device outputs and resolved lines
  logic [7:0] dq_o;
  logic dq_oe, wdo_n, int_oe, rst_oe, desel, int_n, rst_n, kick;
  logic int_lvl, prst_lvl;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n;
  int t0;
  logic [7:0] q;

  rtc_irq_top #(
    .PER_BASE_CYC(32'h0000_0004), .WD_BASE_CYC(32'h0000_0040),
    .WD_RBASE_CYC(32'h0000_0008), .WD_DEF_CYC(32'h0000_0064),
    .WD_RDEF_CYC(32'h0000_000A)
  ) i_rtc_irq_top (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .addr_i(addr), .dq_i(dq),
    .dq_o(dq_o), .dq_oe_o(dq_oe), .cs_n_i(cs_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .time_sec_i(tsec), .time_min_i(tmin),
    .time_hour_i(thour), .time_date_i(tdate), .update_i(upd),
    .supply_fail_i(sfail), .battery_backup_i(bkup), .battery_low_i(blow),
    .watchdog_kick_in_i(kick), .watchdog_expired_out_n_o(wdo_n),
    .int_o(int_lvl), .int_oe_o(int_oe), .proc_rst_o(prst_lvl),
    .proc_rst_oe_o(rst_oe), .bus_deselect_o(desel)
  );

  rtc_host_model i_rtc_host_model (
    .sys_clk_i(sys_clk), .kick_en_i(kick_en), .int_oe_i(int_oe),
    .proc_rst_oe_i(rst_oe), .int_n_o(int_n), .rst_n_o(rst_n), .kick_o(kick)
  );

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Hang guard, far above the expected run length
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One access; strobes held long enough for sync and the flags hold time
  task automatic bus(input logic [3:0] a, input logic [7:0] d,
                     input logic w, output logic [7:0] r);
    @(posedge sys_clk);
    addr <= a;
    dq <= d;
    cs_n <= 1'b0;
    we_n <= ~w;
    oe_n <= w;
    repeat (6) @(posedge sys_clk);
    r = dq_o;
    if (!w) chk({7'h00, dq_oe}, 8'h01);
    cs_n <= 1'b1;
    we_n <= 1'b1;
    oe_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(a, d, 1'b1, r);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] r;
    bus(a, 8'h00, 1'b0, r);
    chk(r, e);
  endtask

  // Bounded wait for a line to reach a level; n counts the cycles
  task automatic wt(input int s, input logic lvl, output int c);
    c = 0;
    while ((s == 0 ? int_n : s == 1 ? desel : s == 2 ? wdo_n : rst_n) !== lvl
           && c < 500) begin
      @(posedge sys_clk);
      #1;
      c++;
    end
    if (c == 500) chk(8'h00, 8'h01);
  endtask

  // First k bytes unmasked and matching, the rest masked with other time
  task automatic alarm(input int k, input bit bad);
    logic [7:0] t[4];
    for (int j = 0; j < 4; j++) begin
      t[j] = (j < k) ? 8'h10 + 8'(j) : 8'h3A;
      wr(4'(2 * j + 1), (j < k) ? t[j] : 8'hC0);
    end
    if (bad) t[k - 1] = t[k - 1] + 8'h01;
    @(posedge sys_clk);
    tsec <= t[0];
    tmin <= t[1];
    thour <= t[2];
    tdate <= t[3];
    upd <= 1'b1;
    @(posedge sys_clk);
    upd <= 1'b0;
  endtask

  initial begin
    {resetn, upd, sfail, bkup, blow} = 5'h00;
    {cs_n, oe_n, we_n, kick_en} = 4'hF;
    addr = 4'h0;
    dq = 8'h00;
    {tsec, tmin, thour, tdate} = 32'h0000_0000;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rd(rtc_irq_pkg::ADDR_INTR, rtc_irq_pkg::INTR_RST);
    chk({6'h00, int_lvl, prst_lvl}, 8'h00);
    rd(4'hE, 8'h00);
    rd(rtc_irq_pkg::ADDR_FLAGS, 8'h01);
    // Alarm enabled, the five mask patterns from all masked to none, each but the first then a near miss
    wr(rtc_irq_pkg::ADDR_INTR, 8'h10);
    for (int k = 0; k < 5; k++) begin
      alarm(k, 1'b0);
      repeat (3) @(posedge sys_clk);
      chk({7'h00, int_n}, 8'h00);
      rd(rtc_irq_pkg::ADDR_FLAGS, 8'h05);
      chk({7'h00, int_n}, 8'h01);
      if (k > 0) begin
        alarm(k, 1'b1);
        rd(rtc_irq_pkg::ADDR_FLAGS, 8'h01);
      end
    end
    // Backup: released until the backup alarm enable is set
    bkup <= 1'b1;
    alarm(4, 1'b0);
    repeat (3) @(posedge sys_clk);
    chk({7'h00, int_n}, 8'h01);
    wr(rtc_irq_pkg::ADDR_INTR, 8'h90);
    repeat (3) @(posedge sys_clk);
    chk({7'h00, int_n}, 8'h00);
    rd(rtc_irq_pkg::ADDR_FLAGS, 8'h05);
    bkup <= 1'b0;
    // Periodic code 4: 4 << 3 cycles between interrupts
    wr(rtc_irq_pkg::ADDR_INTR, 8'h44);
    wt(0, 1'b0, n);
    t0 = cycles;
    rd(rtc_irq_pkg::ADDR_FLAGS, 8'h09);
    wt(0, 1'b0, n);
    chk(8'(cycles - t0), 8'h20);
    wr(rtc_irq_pkg::ADDR_INTR, 8'h40);
    bus(rtc_irq_pkg::ADDR_FLAGS, 8'h00, 1'b0, q);
    repeat (60) @(posedge sys_clk);
    chk({7'h00, int_n}, 8'h01);
    // Power fail: interrupt, then reset and deselect after the delay
    wr(rtc_irq_pkg::ADDR_INTR, 8'h20);
    sfail <= 1'b1;
    wt(0, 1'b0, n);
    t0 = cycles;
    wt(1, 1'b1, n);
    chk({7'h00, (cycles - t0) inside {[38:41]}}, 8'h01);
    chk({7'h00, rst_n}, 8'h00);
    sfail <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rd(rtc_irq_pkg::ADDR_FLAGS, 8'h03);
    // Watchdog code 1: kicked it stays quiet, left alone it fires
    wr(rtc_irq_pkg::ADDR_WDOG, 8'h01);
    repeat (200) @(posedge sys_clk);
    chk({7'h00, wdo_n}, 8'h01);
    kick_en <= 1'b0;
    wt(2, 1'b0, n);
    wt(3, 1'b0, n);
    wt(3, 1'b1, n);
    chk(8'(n), 8'h08);
    kick_en <= 1'b1;
    // Second power-up with a low battery
    @(posedge sys_clk);
    resetn <= 1'b0;
    blow <= 1'b1;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rd(rtc_irq_pkg::ADDR_FLAGS, 8'h00);
    rd(rtc_irq_pkg::ADDR_INTR, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire

// ==== logic/rate_timer.sv ====
// Programmable period timer; emits one tick per period.
// Assumes a synchronous, already released reset from the parent.
`timescale 1ns/1ps
`default_nettype none
module rate_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control from the parent
  rate_timer_if.timer ctl
);
  logic [31:0] count;  // Cycles elapsed in the current period
  logic at_end;        // Last cycle of the period
  logic stopped;       // Limit of zero halts the timer

  assign stopped = (ctl.limit == 32'h0000_0000);
  assign at_end = !stopped && (count >= ctl.limit - 32'h0000_0001);
  assign ctl.tick = at_end && !ctl.restart;

  // Count up and wrap; a restart or stop wins over the wrap
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 32'h0000_0000;
    end else if (ctl.restart || stopped || at_end) begin
      count <= 32'h0000_0000;
    end else begin
      count <= count + 32'h0000_0001;
    end
  end

  // A tick never comes from a stopped timer
  AST_TIMER_STOPPED_SILENT: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    stopped |-> !ctl.tick)
    else $error("timer ticked while stopped");
endmodule
`default_nettype wire

// ==== logic/rate_timer_if.sv ====
// Interface between the control block and a programmable rate timer.
// Assumes one clock shared by both sides.
`timescale 1ns/1ps
`default_nettype none
interface rate_timer_if;
  logic [31:0] limit;   // Period in cycles, zero stops the timer
  logic restart;        // Restart the count from zero
  logic tick;           // One-cycle pulse at the end of each period
  modport owner (output limit, output restart, input tick);
  modport timer (input limit, input restart, output tick);
endinterface
`default_nettype wire

// ==== logic/rtc_irq_pkg.sv ====
// Package for the RTC interrupt block: register map, field positions,
// reset values and the timing constants of the interrupt sources.
// Assumes a 40 MHz system clock.
`default_nettype none
package rtc_irq_pkg;

  // System clock period in picoseconds (40 MHz)
  localparam longint CLK_PERIOD_PS = 25000;

  // Register map, one byte per address
  localparam logic [3:0] ADDR_SEC = 4'h0;
  localparam logic [3:0] ADDR_ALM_SEC = 4'h1;
  localparam logic [3:0] ADDR_MIN = 4'h2;
  localparam logic [3:0] ADDR_ALM_MIN = 4'h3;
  localparam logic [3:0] ADDR_HOUR = 4'h4;
  localparam logic [3:0] ADDR_ALM_HOUR = 4'h5;
  localparam logic [3:0] ADDR_DATE = 4'h6;
  localparam logic [3:0] ADDR_ALM_DATE = 4'h7;
  localparam logic [3:0] ADDR_WDOG = 4'hB;
  localparam logic [3:0] ADDR_INTR = 4'hC;
  localparam logic [3:0] ADDR_FLAGS = 4'hD;

  // Interrupts register fields
  localparam int INTR_ABE_BIT = 7;
  localparam int INTR_PIE_BIT = 6;
  localparam int INTR_POWER_FAIL_IRQ_ENABLE_BIT = 5;
  localparam int INTR_AIE_BIT = 4;
  // Flags register fields
  localparam int FLG_PF_BIT = 3;
  localparam int FLG_AF_BIT = 2;
  localparam int FLG_POWER_FAIL_FLAG_BIT = 1;
  localparam int FLG_BVF_BIT = 0;
  // Alarm byte mask bits
  localparam int MASK_HI_BIT = 7;
  localparam int MASK_LO_BIT = 6;

  // Values after reset
  localparam logic [7:0] ALM_RST = 8'h00;
  localparam logic [7:0] INTR_RST = 8'h00;
  localparam logic [2:0] WDOG_SEL_RST = 3'h0;

  // Periodic base period 30.5175 us
  localparam longint PER_BASE_PS = 30517500;
  localparam longint PER_BASE_CYC = PER_BASE_PS / CLK_PERIOD_PS;
  // Watchdog base (code 1): 23.4375 ms timeout, 3.9063 ms reset
  localparam longint WD_BASE_PS = 23437500000;
  localparam longint WD_BASE_CYC = WD_BASE_PS / CLK_PERIOD_PS;
  localparam longint WD_RBASE_PS = 3906300000;
  localparam longint WD_RBASE_CYC = WD_RBASE_PS / CLK_PERIOD_PS;
  // Watchdog code 0: 1.5 s / 0.25 s, code 7: 3 s / 0.5 s
  localparam longint WD_DEF_PS = 1500000000000;
  localparam longint WD_DEF_CYC = WD_DEF_PS / CLK_PERIOD_PS;
  localparam longint WD_RDEF_PS = 250000000000;
  localparam longint WD_RDEF_CYC = WD_RDEF_PS / CLK_PERIOD_PS;
  localparam longint WD_MAX_PS = 3000000000000;
  localparam longint WD_MAX_CYC = WD_MAX_PS / CLK_PERIOD_PS;
  localparam longint WD_RMAX_PS = 500000000000;
  localparam longint WD_RMAX_CYC = WD_RMAX_PS / CLK_PERIOD_PS;
  // Delay from power-fail interrupt to reset and deselect
  localparam longint WPT_PS = 1000000;
  localparam longint WPT_CYC = WPT_PS / CLK_PERIOD_PS;
  // Least time the address must sit on the flags register
  localparam longint ADDR_HOLD_PS = 50000;
  localparam longint ADDR_HOLD_CYC =
    (ADDR_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage
`default_nettype wire

// ==== logic/rtc_irq_top.sv ====
// Interrupt logic of a parallel-bus RTC: alarm, periodic, power-fail,
// battery check, watchdog, with the byte-wide register port.
// Assumes bus pins and supply indications are asynchronous to sys_clk_i;
// the time counters and update strobe come from clock logic on sys_clk_i.
//
// Contract
// - Each update compares time against four alarm bytes
// - Alarm flag with enable pulls interrupt low
// - Reading flags clears the pending alarm
// - Byte with both top bits set is ignored
// - Masks give second, minute, hour, day, full alarms
// - Interrupt released in backup unless backup alarm enabled
// - Backup alarm enable lets alarm drive interrupt
// - Reset clears alarm enable; alarm then flag only
// - Supply failure sets flag, interrupt if enabled
// - Power-fail interrupt precedes reset by fixed delay
// - Power-fail enable cleared at power-up
// - Low battery at power-up clears valid flag
// - Watchdog select sets timeout and reset width
// - Rate field picks periodic period, zero disables
// - Stable flags read clears flags, releases interrupt
// - Periodic flag set at rate, optional interrupt
// - Any kick level change restarts watchdog
`timescale 1ns/1ps
`default_nettype none
module rtc_irq_top #(
  parameter logic [31:0] PER_BASE_CYC = 32'(rtc_irq_pkg::PER_BASE_CYC),
  parameter logic [31:0] WD_BASE_CYC = 32'(rtc_irq_pkg::WD_BASE_CYC),
  parameter logic [31:0] WD_RBASE_CYC = 32'(rtc_irq_pkg::WD_RBASE_CYC),
  parameter logic [31:0] WD_DEF_CYC = 32'(rtc_irq_pkg::WD_DEF_CYC),
  parameter logic [31:0] WD_RDEF_CYC = 32'(rtc_irq_pkg::WD_RDEF_CYC),
  parameter logic [31:0] WD_MAX_CYC = 32'(rtc_irq_pkg::WD_MAX_CYC),
  parameter logic [31:0] WD_RMAX_CYC = 32'(rtc_irq_pkg::WD_RMAX_CYC)
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Parallel register port (pins)
  input wire logic [3:0] addr_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic dq_oe_o,
  input wire logic cs_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  // Time counters and update strobe from the clock logic
  input wire logic [7:0] time_sec_i,
  input wire logic [7:0] time_min_i,
  input wire logic [7:0] time_hour_i,
  input wire logic [7:0] time_date_i,
  input wire logic update_i,
  // Supply and battery indications (asynchronous)
  input wire logic supply_fail_i,
  input wire logic battery_backup_i,
  input wire logic battery_low_i,
  // Watchdog pins
  input wire logic watchdog_kick_in_i,
  output logic watchdog_expired_out_n_o,
  // Open-drain interrupt and processor reset
  output logic int_o,
  output logic int_oe_o,
  output logic proc_rst_o,
  output logic proc_rst_oe_o,
  // Bus deselected after the write-protect delay
  output logic bus_deselect_o
);
  // Reset release synchroniser
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  // Two-flop synchronisers for every asynchronous pin
  localparam int SW = 19;
  logic [SW-1:0] pin_raw, pin_s1, pin_s2;
  assign pin_raw = {addr_i, dq_i, cs_n_i, oe_n_i, we_n_i, supply_fail_i,
                    battery_backup_i, battery_low_i, watchdog_kick_in_i};
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 19'h7_0000 | 19'h0_0070;
      pin_s2 <= 19'h7_0000 | 19'h0_0070;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  // Synchronised views, read only from the second stage
  logic [3:0] addr;
  logic [7:0] wdata;
  logic cs_n, rd_n, wr_n, supply_fail, in_backup, batt_low, kick;
  assign {addr, wdata, cs_n, rd_n, wr_n, supply_fail, in_backup, batt_low,
          kick} = pin_s2;

  // Registers
  logic [7:0] alarm_byte [4];    // Seconds, minutes, hours, date alarms
  logic [2:0] watchdog_period_select;
  logic [7:0] intr_reg;          // Enables and periodic rate
  logic periodic_flag, alarm_event_flag, power_fail_flag;
  logic battery_valid_flag;
  logic por_checked;             // Battery sampled after release

  // Named fields of the interrupts register
  logic alarm_in_backup_enable, periodic_irq_enable;
  logic power_fail_irq_enable, alarm_irq_enable;
  logic [3:0] periodic_rate_select;
  assign alarm_in_backup_enable = intr_reg[rtc_irq_pkg::INTR_ABE_BIT];
  assign periodic_irq_enable = intr_reg[rtc_irq_pkg::INTR_PIE_BIT];
  assign power_fail_irq_enable = intr_reg[rtc_irq_pkg::INTR_POWER_FAIL_IRQ_ENABLE_BIT];
  assign alarm_irq_enable = intr_reg[rtc_irq_pkg::INTR_AIE_BIT];
  assign periodic_rate_select = intr_reg[3:0];

  // Power-fail sequencing state
  logic deselect;                // Bus cut off, processor held in reset
  logic [15:0] wpt_count;
  logic pf_prev;

  // Bus decode
  logic rd_act, wr_act, rd_flags, clr_done, flags_clear;
  logic [15:0] hold_count;
  logic [7:0] rdata;
  logic [7:0] flags_view;
  assign rd_act = !cs_n && !rd_n && wr_n && !deselect;
  assign wr_act = !cs_n && !wr_n && !deselect;
  assign rd_flags = rd_act && (addr == rtc_irq_pkg::ADDR_FLAGS);
  // Clear only after the address sat still long enough, once per access
  assign flags_clear = rd_flags && !clr_done &&
    (hold_count >= 16'(rtc_irq_pkg::ADDR_HOLD_CYC - 1));
  assign flags_view = {4'h0, periodic_flag, alarm_event_flag,
                       power_fail_flag, battery_valid_flag};

  // Read data selection; reserved addresses read as zero
  always_comb begin
    case (addr)
      rtc_irq_pkg::ADDR_SEC: rdata = time_sec_i;
      rtc_irq_pkg::ADDR_ALM_SEC: rdata = alarm_byte[0];
      rtc_irq_pkg::ADDR_MIN: rdata = time_min_i;
      rtc_irq_pkg::ADDR_ALM_MIN: rdata = alarm_byte[1];
      rtc_irq_pkg::ADDR_HOUR: rdata = time_hour_i;
      rtc_irq_pkg::ADDR_ALM_HOUR: rdata = alarm_byte[2];
      rtc_irq_pkg::ADDR_DATE: rdata = time_date_i;
      rtc_irq_pkg::ADDR_ALM_DATE: rdata = alarm_byte[3];
      rtc_irq_pkg::ADDR_WDOG: rdata = {5'h00, watchdog_period_select};
      rtc_irq_pkg::ADDR_INTR: rdata = intr_reg;
      rtc_irq_pkg::ADDR_FLAGS: rdata = flags_view;
      default: rdata = 8'h00;
    endcase
  end

  // Address hold counter and once-per-access clear latch
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hold_count <= 16'h0000;
      clr_done <= 1'b0;
    end else if (!rd_flags) begin
      hold_count <= 16'h0000;
      clr_done <= 1'b0;
    end else begin
      hold_count <= hold_count + 16'h0001;
      if (flags_clear) begin
        clr_done <= 1'b1;
      end
    end
  end

  // Read data register; frozen on the flags view once cleared so the
  // host sees the flags as they stood before its own clear
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dq_o <= 8'h00;
      dq_oe_o <= 1'b0;
    end else begin
      dq_oe_o <= rd_act;
      if (rd_act && !(rd_flags && (clr_done || flags_clear))) begin
        dq_o <= rdata;
      end
    end
  end

  // Register writes; level-sensitive while the write strobe is low
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        alarm_byte[i] <= rtc_irq_pkg::ALM_RST;
      end
      watchdog_period_select <= rtc_irq_pkg::WDOG_SEL_RST;
      intr_reg <= rtc_irq_pkg::INTR_RST;
    end else if (wr_act) begin
      case (addr)
        rtc_irq_pkg::ADDR_ALM_SEC: alarm_byte[0] <= wdata;
        rtc_irq_pkg::ADDR_ALM_MIN: alarm_byte[1] <= wdata;
        rtc_irq_pkg::ADDR_ALM_HOUR: alarm_byte[2] <= wdata;
        rtc_irq_pkg::ADDR_ALM_DATE: alarm_byte[3] <= wdata;
        rtc_irq_pkg::ADDR_WDOG: watchdog_period_select <= wdata[2:0];
        rtc_irq_pkg::ADDR_INTR: intr_reg <= wdata;
        default: ;
      endcase
    end
  end

  // Alarm compare: a byte matches when masked or equal
  logic [7:0] now_byte [4];
  logic [3:0] byte_hit;
  logic alarm_match;
  assign now_byte[0] = time_sec_i;
  assign now_byte[1] = time_min_i;
  assign now_byte[2] = time_hour_i;
  assign now_byte[3] = time_date_i;
  for (genvar g = 0; g < 4; g++) begin : g_cmp
    logic masked;
    assign masked = alarm_byte[g][rtc_irq_pkg::MASK_HI_BIT] &&
                    alarm_byte[g][rtc_irq_pkg::MASK_LO_BIT];
    assign byte_hit[g] = masked || (alarm_byte[g] == now_byte[g]);
  end
  // All masked fires every update, i.e. once a second; fewer masks
  // narrow it to minute, hour, day or full match
  assign alarm_match = update_i && (&byte_hit);

  // Periodic and watchdog timers
  rate_timer_if per_if ();
  rate_timer_if wd_if ();
  rate_timer u_per (.clk_i(sys_clk_i), .rst_n_i(rst_n), .ctl(per_if));
  rate_timer u_wd (.clk_i(sys_clk_i), .rst_n_i(rst_n), .ctl(wd_if));

  // Periodic period doubles with each code above one
  assign per_if.limit = (periodic_rate_select == 4'h0) ? 32'h0000_0000 :
    PER_BASE_CYC << (periodic_rate_select - 4'h1);
  assign per_if.restart = 1'b0;

  // Watchdog timeout and reset width per select code
  logic [31:0] wd_limit, wd_width;
  always_comb begin
    case (watchdog_period_select)
      3'h0: begin
        wd_limit = WD_DEF_CYC;
        wd_width = WD_RDEF_CYC;
      end
      3'h7: begin
        wd_limit = WD_MAX_CYC;
        wd_width = WD_RMAX_CYC;
      end
      default: begin
        wd_limit = WD_BASE_CYC << (watchdog_period_select - 3'h1);
        wd_width = WD_RBASE_CYC << (watchdog_period_select - 3'h1);
      end
    endcase
  end

  // Kick edge detect on the synchronised level
  logic kick_prev, kick_edge, wd_off;
  assign kick_edge = (kick != kick_prev);
  // Watchdog idles in backup or supply failure
  assign wd_off = in_backup || supply_fail;
  assign wd_if.limit = wd_off ? 32'h0000_0000 : wd_limit;
  assign wd_if.restart = kick_edge;

  // Watchdog output and reset pulse; an unkicked timer keeps wrapping,
  // so the reset repeats once per timeout
  logic [31:0] wd_rst_left;
  logic wd_rst;
  assign wd_rst = (wd_rst_left != 32'h0000_0000);
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      kick_prev <= 1'b0;
      watchdog_expired_out_n_o <= 1'b1;
      wd_rst_left <= 32'h0000_0000;
    end else begin
      kick_prev <= kick;
      if (kick_edge || wd_off) begin
        watchdog_expired_out_n_o <= 1'b1;
      end else if (wd_if.tick) begin
        watchdog_expired_out_n_o <= 1'b0;
      end
      if (wd_if.tick) begin
        wd_rst_left <= wd_width;
      end else if (wd_rst) begin
        wd_rst_left <= wd_rst_left - 32'h0000_0001;
      end
    end
  end

  // Power-fail sequencing: flag now, deselect after the delay
  logic pf_rise;
  assign pf_rise = supply_fail && !pf_prev;
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pf_prev <= 1'b0;
      wpt_count <= 16'h0000;
      deselect <= 1'b0;
    end else begin
      pf_prev <= supply_fail;
      if (!supply_fail) begin
        wpt_count <= 16'h0000;
        deselect <= 1'b0;
      end else if (wpt_count == 16'(rtc_irq_pkg::WPT_CYC - 1)) begin
        deselect <= 1'b1;
      end else begin
        wpt_count <= wpt_count + 16'h0001;
      end
    end
  end

  // Event flags; a set in the clearing cycle wins over the clear
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      periodic_flag <= 1'b0;
      alarm_event_flag <= 1'b0;
      power_fail_flag <= 1'b0;
    end else begin
      periodic_flag <= per_if.tick ||
        (periodic_flag && !flags_clear);
      alarm_event_flag <= alarm_match ||
        (alarm_event_flag && !flags_clear);
      power_fail_flag <= pf_rise ||
        (power_fail_flag && !flags_clear);
    end
  end

  // Battery check once, after the pin synchroniser has refilled; sampling
  // earlier would read its reset value instead of the battery pin
  logic [1:0] por_wait;
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      por_wait <= 2'h0;
      por_checked <= 1'b0;
      battery_valid_flag <= 1'b1;
    end else if (!por_checked) begin
      por_wait <= por_wait + 2'h1;
      if (por_wait == 2'h2) begin
        por_checked <= 1'b1;
        battery_valid_flag <= !batt_low;
      end
    end
  end

  // Interrupt request; in backup only the alarm may drive the pin
  logic irq_alarm, irq_normal, next_irq, irq;
  assign irq_alarm = alarm_event_flag && alarm_irq_enable;
  assign irq_normal = irq_alarm ||
    (periodic_flag && periodic_irq_enable) ||
    (power_fail_flag && power_fail_irq_enable);
  assign next_irq = in_backup ?
    (irq_alarm && alarm_in_backup_enable) : irq_normal;
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // Open-drain pins only ever pull low
  assign int_o = 1'b0;
  assign int_oe_o = irq;
  assign proc_rst_o = 1'b0;
  assign proc_rst_oe_o = deselect || wd_rst || !por_checked;
  assign bus_deselect_o = deselect;

  // Assertions
  AST_ALARM_SETS_FLAG: assert property (
    alarm_match |=> alarm_event_flag)
    else $error("alarm match did not set flag");
  AST_ALARM_IRQ: assert property (
    alarm_event_flag && alarm_irq_enable && !in_backup |=> int_oe_o)
    else $error("enabled alarm flag did not assert interrupt");
  AST_FLAGS_CLEAR: assert property (
    flags_clear && !alarm_match && !per_if.tick && !pf_rise
    |=> !alarm_event_flag && !periodic_flag && !power_fail_flag)
    else $error("flags read did not clear flags");
  AST_CLEAR_NEEDS_HOLD: assert property (
    flags_clear |-> $past(rd_flags))
    else $error("flags cleared without stable address");
  AST_MASKED_BYTE: assert property (
    update_i && (&byte_hit[3:1]) && alarm_byte[0][7:6] == 2'h3
    |=> alarm_event_flag)
    else $error("masked byte blocked the alarm");
  AST_BACKUP_QUIET: assert property (
    in_backup && !alarm_in_backup_enable ##1 in_backup |-> !int_oe_o)
    else $error("interrupt driven in backup without enable");
  AST_WPT_ORDER: assert property (
    $rose(deselect) |-> power_fail_flag || $past(supply_fail, 2))
    else $error("deselect without prior power-fail");
  AST_WPT_DELAY: assert property (
    pf_rise |-> !deselect [*8])
    else $error("deselect came before the delay");
  AST_KICK_RESTART: assert property (
    kick_edge && !wd_off |=> watchdog_expired_out_n_o)
    else $error("kick did not release watchdog output");
  AST_IRQ_HOLD: assert property (
    int_oe_o && !flags_clear && !$past(flags_clear) && !in_backup &&
    $stable(intr_reg)
    |=> int_oe_o)
    else $error("interrupt dropped without flags read");
  AST_POR_ENABLES: assert property (
    !por_checked |-> !alarm_irq_enable && !power_fail_irq_enable)
    else $error("enables not cleared at power-up");
endmodule
`default_nettype wire
